// ==== rtl/pgc_err_tally.sv ====
// Errored-byte tally and received frame counter with overflow flags
`timescale 1ns/1ps
`default_nettype none
module pgc_err_tally
  import pgc_pkg::*;
#(
  parameter int TW = TALLY_W,
  parameter int FW = FRAME_W
)
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          rx_valid,
  input  wire pgc_rx_t       rx,
  input  wire logic          clr_tally,
  input  wire logic          clr_ov,
  output logic      [TW-1:0] tally,
  output logic               byte_ov,
  output logic               frame_tally_overflow
);

  typedef struct packed {
    logic [TW-1:0] tally;
    logic [FW-1:0] frames;
    logic          bov;
    logic          fov;
  } pgc_tly_st_t;

  pgc_tly_st_t   state_r;
  pgc_tly_st_t   state_nxt;
  logic [TW-1:0] tbase;

  always_comb
  begin
    state_nxt = state_r;
    // [R2] clear, then count
    tbase = clr_tally ? '0 : state_r.tally;
    state_nxt.tally = tbase;
    // [R11] overflow clear
    if (clr_ov)
    begin
      state_nxt.bov = 1'h0;
      state_nxt.fov = 1'h0;
    end
    if (rx_valid && rx.err)
    begin
      if (&tbase)
        state_nxt.bov = 1'h1;
      else
        state_nxt.tally = tbase + 1'h1;
    end
    if (rx_valid && rx.last)
    begin
      state_nxt.frames = state_r.frames + 1'h1;
      if (&state_r.frames)
        state_nxt.fov = 1'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign tally                = state_r.tally;
  assign byte_ov              = state_r.bov;
  assign frame_tally_overflow = state_r.fov;

  property p_tally_clear;
    @(posedge pclk) disable iff (!presetn)
    (clr_tally && !(rx_valid && rx.err)) |=> (tally == '0);
  endproperty
  a_tally_clear: assert property (p_tally_clear) else $error("tally not cleared by checker control"); // [R2]

  property p_ov_clear;
    @(posedge pclk) disable iff (!presetn)
    (clr_ov && !rx_valid) |=> (!byte_ov && !frame_tally_overflow);
  endproperty
  a_ov_clear: assert property (p_ov_clear) else $error("overflow flags not cleared"); // [R11]

endmodule : pgc_err_tally
`default_nettype wire

// ==== rtl/pgc_payload_src.sv ====
// Payload byte source: incrementing, fixed fill or pseudo-random
`timescale 1ns/1ps
`default_nettype none
module pgc_payload_src
  import pgc_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] fill,
  input  wire logic       advance,
  output logic      [7:0] byte_o
);

  typedef struct packed {
    logic [7:0]  inc;
    logic [14:0] lfsr;
  } pgc_src_st_t;

  pgc_src_st_t state_r;
  pgc_src_st_t state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    if (advance)
    begin
      state_nxt.inc  = state_r.inc + 8'h01;
      state_nxt.lfsr = prbs_step8(state_r.lfsr);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= '{inc: 8'h00, lfsr: LFSR_SEED};
    else
      state_r <= state_nxt;
  end

  // [R4] mode select
  assign byte_o = (mode == MODE_INC) ? state_r.inc :
                  (mode == MODE_FIX) ? fill : state_r.lfsr[7:0];

  property p_inc_step;
    @(posedge pclk) disable iff (!presetn)
    (advance && mode == MODE_INC) ##1 (mode == MODE_INC) |-> byte_o == 8'($past(byte_o) + 8'h01);
  endproperty
  a_inc_step: assert property (p_inc_step) else $error("incrementing payload did not step by one"); // [R4]

endmodule : pgc_payload_src
`default_nettype wire

// ==== rtl/pgc_pkg.sv ====
// Shared constants, types and helpers for the packet generator configuration block
`default_nettype none
package pgc_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [11:0] IDX_STATUS   = 12'h620;
  localparam logic [11:0] IDX_TALLY_LO = 12'h622;
  localparam logic [11:0] IDX_TALLY_HI = 12'h623;
  localparam logic [11:0] IDX_GEN_CTRL = 12'h624;
  localparam logic [11:0] IDX_PAT_LO   = 12'h625;
  localparam logic [11:0] IDX_PAT_MID  = 12'h626;
  localparam logic [11:0] IDX_PAT_HI   = 12'h627;
  localparam logic [11:0] IDX_CHK_CTRL = 12'h01B;
  localparam logic [11:0] IDX_GEN_CMD  = 12'h630;

  localparam logic [15:0] GEN_CTRL_RST = 16'h5511;
  localparam logic [15:0] PAT_RST      = 16'h0000;

  localparam int GC_FILL_LSB     = 8;
  localparam int GC_MODE_LSB     = 6;
  localparam int GC_VLD_LSB      = 3;
  localparam int GC_CNT_LSB      = 0;
  localparam int CHK_CLR_ALL_BIT = 15;
  localparam int CHK_CLR_CNT_BIT = 14;
  localparam int ST_DONE_BIT     = 12;
  localparam int ST_BUSY_BIT     = 11;
  localparam int ST_FOV_BIT      = 10;
  localparam int ST_BOV_BIT      = 9;
  localparam int CMD_START_BIT   = 0;
  localparam int CMD_STOP_BIT    = 1;

  localparam logic [2:0]  PAT_MAX_BYTES    = 3'h6;
  localparam logic [2:0]  CNT_CONT         = 3'h7;
  localparam logic [1:0]  MODE_INC         = 2'h0;
  localparam logic [1:0]  MODE_FIX         = 2'h1;
  localparam logic [1:0]  SUM_LAST         = 2'h3;
  localparam logic [14:0] LFSR_SEED        = 15'h7FFF;
  localparam int          PAYLOAD_LEN_DFLT = 46;
  localparam int          TALLY_W          = 32;
  localparam int          FRAME_W          = 16;

  typedef enum logic [1:0] {ST_IDLE, ST_PAT, ST_PAY, ST_SUM} pgc_state_t;

  typedef struct packed {
    pgc_state_t st;
    logic [7:0] idx;
  } pgc_pos_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } pgc_tx_t;

  typedef struct packed {
    logic err;
    logic last;
  } pgc_rx_t;

  // Frames per burst for codes 0..6; code 7 never ends
  function automatic logic [19:0] frame_limit(input logic [2:0] code);
    case (code)
      3'h0:    frame_limit = 20'h00001;
      3'h1:    frame_limit = 20'h0000A;
      3'h2:    frame_limit = 20'h00064;
      3'h3:    frame_limit = 20'h003E8;
      3'h4:    frame_limit = 20'h02710;
      3'h5:    frame_limit = 20'h186A0;
      3'h6:    frame_limit = 20'hF4240;
      default: frame_limit = 20'hFFFFF;
    endcase
  endfunction : frame_limit

  // Eight steps of x^15 + x^14 + 1
  function automatic logic [14:0] prbs_step8(input logic [14:0] l);
    logic [14:0] v;
    v = l;
    for (int i = 0; i < 8; i++)
    begin
      v = {v[13:0], v[14] ^ v[13]};
    end
    prbs_step8 = v;
  endfunction : prbs_step8

endpackage : pgc_pkg
`default_nettype wire

// ==== rtl/pgc_top.sv ====
// Packet generator configuration, status registers and frame sequencer
//
// How it works
// [R1] The upper half of the 32-bit errored-byte tally reads as its own register word.
// [R2] Writing a one to bit 15 or bit 14 of the checker control word zeroes the tally.
// [R3] The upper byte of the generator control word is the fill byte sent in fixed mode, reset 0x55.
// [R4] Payload type 0 sends incrementing bytes, 1 the fill byte, 2 and 3 pseudo-random bytes.
// [R5] A three-bit field gives the valid pattern bytes per frame, at most six, reset two.
// [R6] A three-bit burst code sends 1 to 1000000 frames in decades, code 7 without end, reset 1.
// [R7] Pattern bits 15..0 sit in a read/write word that resets to zero.
// [R8] Pattern bits 31..16 sit in a second read/write word that resets to zero.
// [R9] Pattern bits 47..32 sit in a third writable word, completing 48 bits.
// [R10] A read-only done flag rises once every frame of the burst has left with its checksum.
// [R11] Setting bit 15 of the checker control word also clears the overflow flags.
// [R12] Pattern bytes lead each frame from the least significant byte; extra bytes are ignored.
`timescale 1ns/1ps
`default_nettype none
module pgc_top
  import pgc_pkg::*;
#(
  parameter int ADDR_W      = 16,
  parameter int PAYLOAD_LEN = PAYLOAD_LEN_DFLT
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  output pgc_tx_t                tx,
  input  wire logic              rx_valid,
  input  wire pgc_rx_t           rx
);

  typedef struct packed {
    pgc_state_t  st;
    logic [7:0]  idx;
    logic [19:0] frames;
    logic [31:0] sum;
    logic [7:0]  byte_r;
    logic        last;
    logic        done;
    logic [15:0] gen_ctrl;
    logic [15:0] pat_lo;
    logic [15:0] pat_mid;
    logic [15:0] pat_hi;
    logic [31:0] prdata;
    logic        pslverr;
  } pgc_top_st_t;

  typedef struct packed {
    logic [7:0]  b;
    logic [31:0] sum;
    logic        last;
    logic        adv;
  } pgc_ld_t;

  pgc_top_st_t          state_r;
  pgc_top_st_t          state_nxt;
  logic [11:0]          idx_a;
  logic                 addr_ok;
  logic                 wr_hit;
  logic                 start_cmd;
  logic                 stop_cmd;
  logic                 clr_tally;
  logic                 clr_ov;
  logic                 accept;
  logic                 busy;
  logic [7:0]           fill;
  logic [1:0]           mode;
  logic [2:0]           vld;
  logic [2:0]           npat;
  logic [2:0]           cnt_code;
  logic [47:0]          pat48;
  logic [7:0]           pay_byte;
  logic [TALLY_W-1:0]   tally;
  logic                 byte_ov;
  logic                 frame_ov;
  logic [15:0]          rd_word;
  logic [19:0]          nfr;
  pgc_pos_t             pos;
  logic [31:0]          base;
  logic                 go;
  pgc_ld_t              ld;
  logic                 src_adv;
  logic                 ld_pat;
  logic                 ld_pay;
  logic [7:0]           pat_sel;

  // Byte-lane merge of a bus write into a 16-bit word
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
    merge16 = old;
    if (st[0])
      merge16[7:0] = wd[7:0];
    if (st[1])
      merge16[15:8] = wd[15:8];
  endfunction : merge16

  function automatic logic is_mapped(input logic [11:0] i);
    case (i)
      IDX_STATUS, IDX_TALLY_LO, IDX_TALLY_HI, IDX_GEN_CTRL, IDX_PAT_LO,
      IDX_PAT_MID, IDX_PAT_HI, IDX_CHK_CTRL, IDX_GEN_CMD: is_mapped = 1'h1;
      default: is_mapped = 1'h0;
    endcase
  endfunction : is_mapped

  // [R5] a frame opens with pattern bytes only if any are valid
  function automatic pgc_pos_t first_pos(input logic [2:0] np);
    first_pos.st  = (np != 3'h0) ? ST_PAT : ST_PAY;
    first_pos.idx = 8'h00;
  endfunction : first_pos

  function automatic pgc_pos_t next_pos(input pgc_pos_t p, input logic [2:0] np);
    next_pos = p;
    case (p.st)
      ST_PAT:
      begin
        if (p.idx + 8'h01 < {5'h00, np})
          next_pos.idx = p.idx + 8'h01;
        else
          next_pos = '{st: ST_PAY, idx: 8'h00};
      end
      ST_PAY:
      begin
        if (p.idx + 8'h01 < 8'(PAYLOAD_LEN))
          next_pos.idx = p.idx + 8'h01;
        else
          next_pos = '{st: ST_SUM, idx: 8'h00};
      end
      ST_SUM:  next_pos.idx = p.idx + 8'h01;
      default: next_pos = first_pos(np);
    endcase
  endfunction : next_pos

  // Byte that a position carries; the checksum goes out most significant byte first
  function automatic pgc_ld_t load_pos(input pgc_pos_t p, input logic [31:0] bs, input logic [47:0] pt,
                                       input logic [7:0] pb);
    pgc_ld_t r;
    r = '0;
    r.sum = bs;
    case (p.st)
      ST_PAT:
      begin
        r.b   = 8'(pt >> {p.idx, 3'h0});
        r.sum = bs + {24'h000000, r.b};
      end
      ST_PAY:
      begin
        r.b   = pb;
        r.sum = bs + {24'h000000, pb};
        r.adv = 1'h1;
      end
      ST_SUM:
      begin
        r.b    = 8'(bs >> {~p.idx[1:0], 3'h0});
        r.last = (p.idx[1:0] == SUM_LAST);
      end
      default: r = '0;
    endcase
    load_pos = r;
  endfunction : load_pos

  assign idx_a    = paddr[13:2];
  assign addr_ok  = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:14] == '0) && is_mapped(idx_a);
  assign wr_hit   = psel && penable && pwrite && addr_ok;
  assign start_cmd = wr_hit && idx_a == IDX_GEN_CMD && pstrb[0] && pwdata[CMD_START_BIT];
  assign stop_cmd  = wr_hit && idx_a == IDX_GEN_CMD && pstrb[0] && pwdata[CMD_STOP_BIT];
  // [R2] either top bit clears the tally
  assign clr_tally = wr_hit && idx_a == IDX_CHK_CTRL && pstrb[1] &&
                     (pwdata[CHK_CLR_ALL_BIT] || pwdata[CHK_CLR_CNT_BIT]);
  // [R11] only the top bit clears the overflow flags
  assign clr_ov    = wr_hit && idx_a == IDX_CHK_CTRL && pstrb[1] && pwdata[CHK_CLR_ALL_BIT];

  assign fill     = state_r.gen_ctrl[GC_FILL_LSB +: 8];
  assign mode     = state_r.gen_ctrl[GC_MODE_LSB +: 2];
  assign vld      = state_r.gen_ctrl[GC_VLD_LSB +: 3];
  assign cnt_code = state_r.gen_ctrl[GC_CNT_LSB +: 3];
  // [R5] counts above six are held at six
  assign npat     = (vld > PAT_MAX_BYTES) ? PAT_MAX_BYTES : vld;
  assign pat48    = {state_r.pat_hi, state_r.pat_mid, state_r.pat_lo};
  assign busy     = (state_r.st != ST_IDLE);
  assign accept   = busy && tx_ready;

  always_comb
  begin
    state_nxt = state_r;
    rd_word   = 16'h0000;
    nfr       = state_r.frames + 20'h00001;
    pos       = first_pos(npat);
    base      = 32'h00000000;
    go        = 1'h0;

    if (wr_hit)
    begin
      case (idx_a)
        IDX_GEN_CTRL: state_nxt.gen_ctrl = merge16(state_r.gen_ctrl, pwdata, pstrb);
        // [R7] low pattern word
        IDX_PAT_LO:   state_nxt.pat_lo   = merge16(state_r.pat_lo, pwdata, pstrb);
        // [R8] middle pattern word
        IDX_PAT_MID:  state_nxt.pat_mid  = merge16(state_r.pat_mid, pwdata, pstrb);
        // [R9] top pattern word
        IDX_PAT_HI:   state_nxt.pat_hi   = merge16(state_r.pat_hi, pwdata, pstrb);
        default:      ;
      endcase
    end

    case (idx_a)
      IDX_STATUS:
      begin
        rd_word[ST_DONE_BIT] = state_r.done;
        rd_word[ST_BUSY_BIT] = busy;
        rd_word[ST_FOV_BIT]  = frame_ov;
        rd_word[ST_BOV_BIT]  = byte_ov;
      end
      IDX_TALLY_LO: rd_word = tally[15:0];
      // [R1] upper tally half
      IDX_TALLY_HI: rd_word = tally[31:16];
      IDX_GEN_CTRL: rd_word = state_r.gen_ctrl;
      IDX_PAT_LO:   rd_word = state_r.pat_lo;
      IDX_PAT_MID:  rd_word = state_r.pat_mid;
      IDX_PAT_HI:   rd_word = state_r.pat_hi;
      default:      rd_word = 16'h0000;
    endcase

    // Read data and error are captured in the setup cycle
    if (psel && !penable)
    begin
      state_nxt.prdata  = {16'h0000, rd_word};
      state_nxt.pslverr = !addr_ok;
    end

    if (start_cmd && !busy)
    begin
      go               = 1'h1;
      state_nxt.frames = 20'h00000;
      state_nxt.done   = 1'h0;
    end
    else if (accept)
    begin
      if (state_r.last)
      begin
        state_nxt.frames = nfr;
        // [R6] burst ends after the coded frame count
        if (cnt_code != CNT_CONT && nfr == frame_limit(cnt_code))
        begin
          state_nxt.st   = ST_IDLE;
          state_nxt.last = 1'h0;
          // [R10] done once the last checksum byte is taken
          state_nxt.done = 1'h1;
        end
        else
        begin
          go = 1'h1;
        end
      end
      else
      begin
        go   = 1'h1;
        pos  = next_pos('{st: state_r.st, idx: state_r.idx}, npat);
        base = state_r.sum;
      end
    end

    // [R12] pattern bytes go out least significant first
    ld = load_pos(pos, base, pat48, pay_byte);
    if (go)
    begin
      state_nxt.st     = pos.st;
      state_nxt.idx    = pos.idx;
      state_nxt.byte_r = ld.b;
      state_nxt.sum    = ld.sum;
      state_nxt.last   = ld.last;
    end
    if (stop_cmd)
    begin
      state_nxt.st   = ST_IDLE;
      state_nxt.last = 1'h0;
    end
  end

  assign src_adv = go && ld.adv;
  assign ld_pat  = go && pos.st == ST_PAT;
  assign ld_pay  = go && pos.st == ST_PAY;
  assign pat_sel = 8'(pat48 >> {pos.idx, 3'h0});

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r          <= '0;
      state_r.st       <= ST_IDLE;
      // [R3] fill 0x55, fixed reset word
      state_r.gen_ctrl <= GEN_CTRL_RST;
      state_r.pat_lo   <= PAT_RST;
      state_r.pat_mid  <= PAT_RST;
      state_r.pat_hi   <= PAT_RST;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  pgc_payload_src u_src (
    .pclk    (pclk),
    .presetn (presetn),
    .mode    (mode),
    .fill    (fill),
    .advance (src_adv),
    .byte_o  (pay_byte)
  );

  pgc_err_tally #(
    .TW (TALLY_W),
    .FW (FRAME_W)
  ) u_tally (
    .pclk                 (pclk),
    .presetn              (presetn),
    .rx_valid             (rx_valid),
    .rx                   (rx),
    .clr_tally            (clr_tally),
    .clr_ov               (clr_ov),
    .tally                (tally),
    .byte_ov              (byte_ov),
    .frame_tally_overflow (frame_ov)
  );

  assign prdata   = state_r.prdata;
  assign pslverr  = state_r.pslverr;
  assign pready   = 1'h1;
  assign tx_valid = busy;
  // One driver for the whole byte-stream struct
  assign tx       = '{data: state_r.byte_r, last: state_r.last};

  property p_tally_hi_read;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && addr_ok && idx_a == IDX_TALLY_HI) |=> (prdata == {16'h0000, $past(tally[31:16])});
  endproperty
  a_tally_hi_read: assert property (p_tally_hi_read) else $error("upper tally read mismatch"); // [R1]

  property p_fill_sent;
    @(posedge pclk) disable iff (!presetn)
    (ld_pay && mode == MODE_FIX) |=> (tx.data == $past(fill));
  endproperty
  a_fill_sent: assert property (p_fill_sent) else $error("fixed mode did not send the fill byte"); // [R3]

  property p_pat_bound;
    @(posedge pclk) disable iff (!presetn)
    (state_r.st == ST_PAT) |-> (state_r.idx < 8'h06 && state_r.idx < {5'h00, npat});
  endproperty
  a_pat_bound: assert property (p_pat_bound) else $error("pattern byte beyond valid count"); // [R5]

  property p_burst_end;
    @(posedge pclk) disable iff (!presetn)
    (accept && tx.last && !stop_cmd && cnt_code != CNT_CONT &&
     state_r.frames + 20'h00001 == frame_limit(cnt_code)) |=> (state_r.done && !tx_valid);
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("burst did not end at its frame count"); // [R6]

  property p_endless;
    @(posedge pclk) disable iff (!presetn)
    (tx_valid && cnt_code == CNT_CONT && !stop_cmd) |=> tx_valid;
  endproperty
  a_endless: assert property (p_endless) else $error("endless burst stopped"); // [R6]

  property p_pat_lo_wr;
    @(posedge pclk) disable iff (!presetn)
    (wr_hit && idx_a == IDX_PAT_LO && pstrb[1:0] == 2'h3) |=> (state_r.pat_lo == $past(pwdata[15:0]));
  endproperty
  a_pat_lo_wr: assert property (p_pat_lo_wr) else $error("low pattern word not written"); // [R7]

  property p_pat_mid_lane;
    @(posedge pclk) disable iff (!presetn)
    (wr_hit && idx_a == IDX_PAT_MID && pstrb[1:0] == 2'h2) |=>
      (state_r.pat_mid == {$past(pwdata[15:8]), $past(state_r.pat_mid[7:0])});
  endproperty
  a_pat_mid_lane: assert property (p_pat_mid_lane) else $error("middle pattern lane write wrong"); // [R8]

  property p_pat_hi_wr;
    @(posedge pclk) disable iff (!presetn)
    (wr_hit && idx_a == IDX_PAT_HI && pstrb[1:0] == 2'h3) ##2 (psel && !penable && idx_a == IDX_PAT_HI)
      |=> (prdata[15:0] == $past(pwdata[15:0], 3));
  endproperty
  a_pat_hi_wr: assert property (p_pat_hi_wr) else $error("top pattern word readback wrong"); // [R9]

  property p_done_cause;
    @(posedge pclk) disable iff (!presetn)
    $rose(state_r.done) |-> $past(accept && tx.last);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("done rose without a final checksum byte"); // [R10]

  property p_pat_order;
    @(posedge pclk) disable iff (!presetn)
    (ld_pat && !stop_cmd) |=> (tx.data == $past(pat_sel) && state_r.st == ST_PAT);
  endproperty
  a_pat_order: assert property (p_pat_order) else $error("pattern byte out of order"); // [R12]

endmodule : pgc_top
`default_nettype wire

// ==== tb/pgc_link_partner.sv ====
// Far-side model: stalling byte sink and errored-byte source
`timescale 1ns/1ps
`default_nettype none
module pgc_link_partner
  import pgc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic flood,
  output logic      tx_ready,
  output logic      rx_valid,
  output pgc_rx_t   rx
);
  // Idle rx lines toggle so a stale value is never mistaken for a byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx       <= '0;
    end
    else
    begin
      tx_ready <= 1'($urandom_range(0, 1));
      rx_valid <= flood;
      rx       <= flood ? 2'b11 : ~rx;
    end
  end
endmodule : pgc_link_partner
`default_nettype wire

// ==== tb/pgc_top_bench.sv ====
// Self-checking bench for the packet generator configuration block
`timescale 1ns/1ps
`default_nettype none
module pgc_top_bench
  import pgc_pkg::*;
;
  logic [3:0]  pstrb = 4'hF;
  logic [7:0]  inc_m = 8'h00;
  logic [14:0] lfsr_m = LFSR_SEED;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, flood = 1'b0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr, tx_valid, tx_ready, rx_valid, bus_err;
  pgc_tx_t     tx;
  pgc_rx_t     rx;
  pgc_tx_t     got_q[$];
  int          n_errors = 0, compares = 0, cyc = 0;

  pgc_top #(.PAYLOAD_LEN(4)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx(tx), .rx_valid(rx_valid), .rx(rx));
  pgc_link_partner partner (.pclk(pclk), .presetn(presetn), .flood(flood), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx(rx));

  always #5 pclk = ~pclk;

  always @(posedge pclk)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      got_q.push_back(tx);
    cyc++;
    if (cyc == 90000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] idx, input logic [15:0] wd, output logic [15:0] rd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= 16'({idx, 2'b00});
    pwdata  <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata[15:0];
    bus_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk_frame(input int n, input logic [1:0] m, input logic [7:0] fill, input logic [47:0] pat);
    int          len;
    logic [31:0] sum;
    logic [7:0]  e;
    pgc_tx_t     t;
    len = n + 8;
    sum = '0;
    chk("bytes queued", 1, got_q.size() >= len);
    if (got_q.size() < len)
      return;
    for (int i = 0; i < len; i++)
    begin
      t = got_q.pop_front();
      if (i < n)
        e = pat[8*i +: 8];
      else if (i < n + 4)
      begin
        // Payload sources run on across frames and bursts, whatever the mode
        e = (m == MODE_INC) ? inc_m : (m == MODE_FIX) ? fill : lfsr_m[7:0];
        inc_m++;
        repeat (8) lfsr_m = {lfsr_m[13:0], lfsr_m[14] ^ lfsr_m[13]};
      end
      else
        e = sum[8*(len-1-i) +: 8];
      if (i < n + 4)
        sum += 32'(e);
      chk("tx data", e, t.data);
      chk("tx last", i == len - 1, t.last);
    end
  endtask : chk_frame

  initial
  begin
    logic [15:0] rd;
    logic [47:0] pat;
    logic [7:0]  fill;
    logic [1:0]  m;
    int          nv, code;
    void'($urandom(54825));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, IDX_GEN_CTRL, 0, rd);
    chk("gen ctrl reset", GEN_CTRL_RST, rd);
    apb(0, IDX_PAT_LO, 0, rd);
    chk("pattern low reset", 0, rd);
    apb(0, IDX_PAT_MID, 0, rd);
    chk("pattern mid reset", 0, rd);
    apb(1, IDX_TALLY_HI, 16'hFFFF, rd);
    apb(0, IDX_TALLY_HI, 0, rd);
    chk("tally high read-only", 0, rd);
    apb(0, 12'h621, 0, rd);
    chk("unmapped error", 1, bus_err);
    apb(1, IDX_PAT_MID, 16'hA5C3, rd);
    pstrb <= 4'h2;
    apb(1, IDX_PAT_MID, 16'h5A3C, rd);
    pstrb <= 4'hF;
    apb(0, IDX_PAT_MID, 0, rd);
    chk("pattern mid lane", 16'h5AC3, rd);
    for (int i = 0; i < 5; i++)
    begin
      m    = 2'(i);
      nv   = (2 * i + 1) % 8;
      code = (i == 4) ? 1 : 0;
      fill = 8'($urandom);
      pat  = {16'($urandom), 32'($urandom)};
      for (int j = 0; j < 3; j++)
      begin
        apb(1, IDX_PAT_LO + 12'(j), pat[16*j +: 16], rd);
        apb(0, IDX_PAT_LO + 12'(j), 0, rd);
        chk("pattern word", pat[16*j +: 16], rd);
      end
      apb(1, IDX_GEN_CTRL, {fill, m, 3'(nv), 3'(code)}, rd);
      apb(0, IDX_GEN_CTRL, 0, rd);
      chk("gen ctrl", {fill, m, 3'(nv), 3'(code)}, rd);
      got_q.delete();
      apb(1, IDX_GEN_CMD, 16'h0001, rd);
      rd = '0;
      for (int k = 0; k < 300 && rd[ST_DONE_BIT] !== 1'b1; k++)
        apb(0, IDX_STATUS, 0, rd);
      chk("burst done", 1, rd[ST_DONE_BIT]);
      repeat (code ? 10 : 1) chk_frame(nv > 6 ? 6 : nv, m, fill, pat);
      chk("frames beyond burst", 0, got_q.size());
    end
    // Endless burst runs until the stop command
    apb(1, IDX_GEN_CTRL, {8'h00, MODE_INC, 3'h0, CNT_CONT}, rd);
    got_q.delete();
    apb(1, IDX_GEN_CMD, 16'h0001, rd);
    repeat (200) @(posedge pclk);
    apb(0, IDX_STATUS, 0, rd);
    chk("endless busy", 1, rd[ST_BUSY_BIT]);
    chk("endless done", 0, rd[ST_DONE_BIT]);
    apb(1, IDX_GEN_CMD, 16'h0002, rd);
    @(posedge pclk);
    chk("valid after stop", 0, tx_valid);
    chk("endless frames", 1, got_q.size() > 16);
    // Enough errored frame-ending bytes to carry into the upper word and wrap the frame count
    flood <= 1'b1;
    repeat (65540) @(posedge pclk);
    flood <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(0, IDX_TALLY_HI, 0, rd);
    chk("tally high", 16'h0001, rd);
    apb(0, IDX_STATUS, 0, rd);
    chk("frame overflow", 1, rd[ST_FOV_BIT]);
    apb(1, IDX_CHK_CTRL, 16'h4000, rd);
    apb(0, IDX_TALLY_HI, 0, rd);
    chk("tally high cleared", 0, rd);
    apb(0, IDX_STATUS, 0, rd);
    chk("frame overflow kept", 1, rd[ST_FOV_BIT]);
    flood <= 1'b1;
    repeat (5) @(posedge pclk);
    flood <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1, IDX_CHK_CTRL, 16'h8000, rd);
    apb(0, IDX_TALLY_LO, 0, rd);
    chk("tally cleared by top bit", 0, rd);
    apb(0, IDX_STATUS, 0, rd);
    chk("frame overflow cleared", 0, rd[ST_FOV_BIT]);
    tally_and_finish();
  end
endmodule : pgc_top_bench
`default_nettype wire
